/* qdsl_chan_store.v */
// Input register store for the converter channels
`timescale 1ns/10ps
module qdsl_chan_store #(
	parameter NUM = 4,
	parameter W = 16
)(
	input wire clk,
	input wire rst,
	input wire [NUM-1:0] wrMask,
	input wire [W-1:0] wrData,
	output wire [NUM*W-1:0] words
);

reg [W-1:0] word_r [0:NUM-1];

genvar gi;
generate
	for (gi = 0; gi < NUM; gi = gi + 1)
	begin : g_word
		always @(posedge clk)
		begin
			if (rst)
				word_r[gi] <= {W{1'b0}};
			else if (wrMask[gi])
				word_r[gi] <= wrData;
		end
		assign words[gi*W +: W] = word_r[gi];
	end
endgenerate

endmodule

/* qdsl_consts.vh */
// Constants for the quad converter serial load port
`ifndef QDSL_CONSTS_VH
`define QDSL_CONSTS_VH

// Frame geometry
`define QDSL_FRAME_BITS 6'd32
`define QDSL_CNT_W 6
`define QDSL_CHANNELS 4
`define QDSL_CODE_W 16

// Command word fields
`define QDSL_CMD_HI 27
`define QDSL_CMD_LO 24
`define QDSL_ADDR_HI 23
`define QDSL_ADDR_LO 20
`define QDSL_DATA_HI 19
`define QDSL_DATA_LO 4

// Command codes
`define QDSL_CMD_WRITE 4'h0
`define QDSL_CMD_UPDATE 4'h1
`define QDSL_CMD_WRITE_UPD_ALL 4'h2
`define QDSL_CMD_WRITE_UPD 4'h3
`define QDSL_CMD_CLR_SEL 4'h5
`define QDSL_CMD_LOAD_MASK 4'h6

// Channel address meaning every channel
`define QDSL_ADDR_ALL 4'hf

// Clear code select values, low two data bits
`define QDSL_CLRSEL_ZERO 2'h0
`define QDSL_CLRSEL_MID 2'h1
`define QDSL_CLRSEL_FULL 2'h2

// Output codes
`define QDSL_CODE_ZERO 16'h0000
`define QDSL_CODE_MID 16'h8000
`define QDSL_CODE_FULL 16'hffff

// Reset values
`define QDSL_RST_CLEAR_CODE 16'h0000
`define QDSL_RST_LOAD_MASK 4'hf
`define QDSL_RST_PINS 6'h3f

// Cycles after reset release before the level select pin is trusted
`define QDSL_POR_WAIT 2'h2

`endif

/* qdsl_host_model.sv */
// Serial bus master model that frames words into the load port
`timescale 1ns/10ps
module qdsl_host_model (
	input wire ref_clk,
	input wire serial_out,
	output reg frameSyncN,
	output reg serialClk,
	output reg serialIn
);
	reg [31:0] readBack;
	initial
	begin
		frameSyncN = 1'b1;
		serialClk = 1'b1;
		serialIn = 1'b0;
		readBack = 32'h0;
	end
	// Half of the 48 ns link period
	task hold;
	begin
		repeat (6) @(posedge ref_clk);
	end
	endtask
	task send(input [31:0] word, input integer nBits);
		integer i;
	begin
		frameSyncN <= 1'b0;
		for (i = 0; i < nBits; i = i + 1)
		begin
			serialIn <= word[31-i];
			hold;
			serialClk <= 1'b0;
			readBack <= {readBack[30:0], serial_out};
			hold;
			serialClk <= 1'b1;
		end
		hold;
		frameSyncN <= 1'b1;
		// Released line must not keep a stale bit
		serialIn <= ~serialIn;
	end
	endtask
endmodule

/* qdsl_serial_port.v */
// Serial load port, input and converter registers of a quad converter
//
// Summary of operation
// - Load strobe low moves pending input registers into selected converter registers.
// - Frame sync falling edge arms the shift register for a new frame.
// - Capture one data bit on each of the next 32 serial clock falls.
// - Frame sync rising before the 32nd fall aborts and discards the write.
// - After power-up outputs go to zero or midscale per level select pin.
// - Serial output changes on rising clock edges, sampled on following falls.
// - Serial output presents shift register contents for chaining and readback.
// - Clear low loads the chosen code into all input and converter registers.
// - Clear code is zero until a command selects another.
// - Input path is a 32-bit shift register clocked on serial clock falls.
`timescale 1ns/10ps
`include "qdsl_consts.vh"
module qdsl_serial_port (
	input wire ref_clk,
	input wire rst,
	input wire frameSyncN,
	input wire serialClk,
	input wire serialIn,
	input wire load_strobe_n,
	input wire clear_n,
	input wire porLevelSel,
	output reg serial_out,
	output reg [`QDSL_CHANNELS*`QDSL_CODE_W-1:0] dacCodes_r
);

localparam ST_IDLE = 1'b0;
localparam ST_SHIFT = 1'b1;
localparam NCH = `QDSL_CHANNELS;
localparam CW = `QDSL_CODE_W;

// -----------------------------------------------------------------
// Channel address decode
// -----------------------------------------------------------------
function [NCH-1:0] chanMask;
	input [3:0] addr;
	begin
		if (addr == `QDSL_ADDR_ALL)
			chanMask = {NCH{1'b1}};
		else if (addr < NCH)
			chanMask = {{(NCH-1){1'b0}}, 1'b1} << addr[1:0];
		else
			chanMask = {NCH{1'b0}};
	end
endfunction

// -----------------------------------------------------------------
// Pin synchronisers and edge detection
// -----------------------------------------------------------------
reg [5:0] pinMeta_r;
reg [5:0] pinSync_r;
reg sclkPrev_r;
reg fsPrev_r;

always @(posedge ref_clk)
begin
	if (rst)
	begin
		pinMeta_r <= `QDSL_RST_PINS;
		pinSync_r <= `QDSL_RST_PINS;
		sclkPrev_r <= 1'b1;
		fsPrev_r <= 1'b1;
	end
	else
	begin
		pinMeta_r <= {porLevelSel, clear_n, load_strobe_n, serialIn, serialClk, frameSyncN};
		pinSync_r <= pinMeta_r;
		sclkPrev_r <= pinSync_r[1];
		fsPrev_r <= pinSync_r[0];
	end
end

wire fsS = pinSync_r[0];
wire sclkS = pinSync_r[1];
wire dinS = pinSync_r[2];
wire ldS = pinSync_r[3];
wire clrS = pinSync_r[4];
wire porS = pinSync_r[5];
wire fsFall = fsPrev_r & ~fsS;
wire fsRise = ~fsPrev_r & fsS;
wire sclkFall = sclkPrev_r & ~sclkS;
wire sclkRise = ~sclkPrev_r & sclkS;

// -----------------------------------------------------------------
// Frame state
// -----------------------------------------------------------------
reg state_r;
reg state_nxt;
reg [31:0] shift_r;
reg [31:0] shift_nxt;
reg [`QDSL_CNT_W-1:0] cnt_r;
reg [`QDSL_CNT_W-1:0] cnt_nxt;
reg serialOut_nxt;
reg exec;

always @*
begin
	state_nxt = state_r;
	shift_nxt = shift_r;
	cnt_nxt = cnt_r;
	serialOut_nxt = serial_out;
	exec = 1'b0;
	case (state_r)
		ST_IDLE:
		begin
			if (fsFall)
			begin
				state_nxt = ST_SHIFT;
				cnt_nxt = {`QDSL_CNT_W{1'b0}};
			end
		end
		ST_SHIFT:
		begin
			if (sclkFall)
			begin
				shift_nxt = {shift_r[30:0], dinS};
				if (cnt_r != `QDSL_FRAME_BITS)
					cnt_nxt = cnt_r + 6'd1;
			end
			if (sclkRise)
				serialOut_nxt = shift_r[31];
			if (fsRise)
			begin
				state_nxt = ST_IDLE;
				exec = (cnt_nxt == `QDSL_FRAME_BITS);
			end
		end
		default:
			state_nxt = ST_IDLE;
	endcase
end

// -----------------------------------------------------------------
// Register update control
// -----------------------------------------------------------------
wire [NCH*CW-1:0] words;
reg [NCH-1:0] dirty_r;
reg [NCH-1:0] dirty_nxt;
reg [NCH-1:0] loadMask_r;
reg [NCH-1:0] loadMask_nxt;
reg [CW-1:0] clearCode_r;
reg [CW-1:0] clearCode_nxt;
reg [1:0] porWait_r;
reg [NCH-1:0] storeMask;
reg [CW-1:0] storeData;
reg [NCH-1:0] directMask;
reg [NCH-1:0] updMask;
reg [NCH-1:0] setMask;

wire [3:0] cmd = shift_nxt[`QDSL_CMD_HI:`QDSL_CMD_LO];
wire [NCH-1:0] amask = chanMask(shift_nxt[`QDSL_ADDR_HI:`QDSL_ADDR_LO]);
wire [CW-1:0] fdata = shift_nxt[`QDSL_DATA_HI:`QDSL_DATA_LO];

always @*
begin
	storeMask = {NCH{1'b0}};
	storeData = fdata;
	directMask = {NCH{1'b0}};
	updMask = {NCH{1'b0}};
	setMask = {NCH{1'b0}};
	loadMask_nxt = loadMask_r;
	clearCode_nxt = clearCode_r;
	if (!clrS)
	begin
		storeMask = {NCH{1'b1}};
		storeData = clearCode_r;
		directMask = {NCH{1'b1}};
		updMask = {NCH{1'b1}};
	end
	else if (porWait_r == `QDSL_POR_WAIT)
	begin
		storeMask = {NCH{1'b1}};
		storeData = porS ? `QDSL_CODE_MID : `QDSL_CODE_ZERO;
		directMask = {NCH{1'b1}};
		updMask = {NCH{1'b1}};
	end
	else
	begin
		if (!ldS)
			updMask = dirty_r & loadMask_r;
		if (exec)
		begin
			case (cmd)
				`QDSL_CMD_WRITE:
				begin
					storeMask = amask;
					setMask = amask;
				end
				`QDSL_CMD_UPDATE:
					updMask = updMask | amask;
				`QDSL_CMD_WRITE_UPD_ALL:
				begin
					storeMask = amask;
					directMask = amask;
					updMask = {NCH{1'b1}};
				end
				`QDSL_CMD_WRITE_UPD:
				begin
					storeMask = amask;
					directMask = amask;
					updMask = updMask | amask;
				end
				`QDSL_CMD_CLR_SEL:
				begin
					case (fdata[1:0])
						`QDSL_CLRSEL_MID: clearCode_nxt = `QDSL_CODE_MID;
						`QDSL_CLRSEL_FULL: clearCode_nxt = `QDSL_CODE_FULL;
						default: clearCode_nxt = `QDSL_CODE_ZERO;
					endcase
				end
				`QDSL_CMD_LOAD_MASK:
					loadMask_nxt = fdata[NCH-1:0];
				default:
					storeMask = {NCH{1'b0}};
			endcase
		end
	end
	// A new write wins over a same-cycle transfer of the old word
	dirty_nxt = (dirty_r & ~updMask) | setMask;
end

qdsl_chan_store #(
	.NUM(NCH),
	.W(CW)
) u_store (
	.clk(ref_clk),
	.rst(rst),
	.wrMask(storeMask),
	.wrData(storeData),
	.words(words)
);

always @(posedge ref_clk)
begin
	if (rst)
	begin
		state_r <= ST_IDLE;
		shift_r <= 32'h00000000;
		cnt_r <= {`QDSL_CNT_W{1'b0}};
		serial_out <= 1'b0;
		dirty_r <= {NCH{1'b0}};
		loadMask_r <= `QDSL_RST_LOAD_MASK;
		clearCode_r <= `QDSL_RST_CLEAR_CODE;
		porWait_r <= 2'h0;
	end
	else
	begin
		state_r <= state_nxt;
		shift_r <= shift_nxt;
		cnt_r <= cnt_nxt;
		serial_out <= serialOut_nxt;
		dirty_r <= dirty_nxt;
		loadMask_r <= loadMask_nxt;
		clearCode_r <= clearCode_nxt;
		if (porWait_r != 2'h3)
			porWait_r <= porWait_r + 2'h1;
	end
end

// -----------------------------------------------------------------
// Converter registers
// -----------------------------------------------------------------
genvar gi;
generate
	for (gi = 0; gi < NCH; gi = gi + 1)
	begin : g_dac
		always @(posedge ref_clk)
		begin
			if (rst)
				dacCodes_r[gi*CW +: CW] <= `QDSL_CODE_ZERO;
			else if (directMask[gi])
				dacCodes_r[gi*CW +: CW] <= storeData;
			else if (updMask[gi])
				dacCodes_r[gi*CW +: CW] <= words[gi*CW +: CW];
		end
	end
endgenerate

endmodule

/* qdsl_serial_port_chk.sv */
// Port checker for the quad converter serial load port
`timescale 1ns/10ps
module qdsl_serial_port_chk (
	input wire ref_clk,
	input wire rst,
	input wire frameSyncN,
	input wire serialClk,
	input wire serialIn,
	input wire load_strobe_n,
	input wire clear_n,
	input wire porLevelSel,
	input wire serial_out,
	input wire [63:0] dacCodes_r
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	property p_rst0;
		$fell(rst) |-> dacCodes_r == 64'h0 && !serial_out;
	endproperty
	a_rst0: assert property (p_rst0) else $error("outputs not clear after reset");
	property p_pwr;
		$fell(rst) |-> ##4 dacCodes_r == (porLevelSel ? {4{16'h8000}} : 64'h0);
	endproperty
	a_pwr: assert property (p_pwr) else $error("wrong power-up code");
	property p_clr;
		(!clear_n)[*5] |-> dacCodes_r == {4{dacCodes_r[15:0]}};
	endproperty
	a_clr: assert property (p_clr) else $error("clear left channels apart");
	property p_open;
		(!frameSyncN && load_strobe_n && clear_n)[*8] |=> $stable(dacCodes_r);
	endproperty
	a_open: assert property (p_open) else $error("codes moved inside a frame");
	property p_quiet;
		(frameSyncN && load_strobe_n && clear_n)[*8] |=> $stable(dacCodes_r);
	endproperty
	a_quiet: assert property (p_quiet) else $error("codes moved while idle");
	property p_idle;
		frameSyncN[*8] |=> $stable(serial_out);
	endproperty
	a_idle: assert property (p_idle) else $error("serial output moved idle");
	property p_rise;
		$changed(serial_out) |-> $past(serialClk, 3);
	endproperty
	a_rise: assert property (p_rise) else $error("serial output moved off rise");
	property p_low;
		(!serialClk)[*4] |-> $stable(serial_out);
	endproperty
	a_low: assert property (p_low) else $error("serial output moved while low");
endmodule

bind qdsl_serial_port qdsl_serial_port_chk i_chk (.*);

/* tb_qdsl_serial_port.sv */
// Self-checking bench for the quad converter serial load port
`timescale 1ns/10ps
module tb_qdsl_serial_port;
	reg ref_clk = 1'b0;
	reg rst = 1'b1;
	reg load_strobe_n = 1'b1;
	reg clear_n = 1'b1;
	reg porLevelSel = 1'b1;
	wire frameSyncN, serialClk, serialIn, serial_out;
	wire [63:0] dacCodes_r;
	reg [63:0] expDac;
	integer bad_count = 0;
	integer cmp_count = 0;
	always #2 ref_clk = ~ref_clk;
	qdsl_host_model i_qdsl_host_model (.*);
	qdsl_serial_port i_qdsl_serial_port (.*);
	task check(input [63:0] seen, input [63:0] want);
	begin
		cmp_count = cmp_count + 1;
		if (seen !== want)
		begin
			bad_count = bad_count + 1;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, want);
		end
	end
	endtask
	task report_and_stop;
	begin
		if (bad_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask
	task do_reset(input lvl);
	begin
		@(posedge ref_clk);
		rst <= 1'b1;
		porLevelSel <= lvl;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (6) @(posedge ref_clk);
	end
	endtask
	task frame(input [3:0] cmd, input [3:0] ch, input [15:0] d, input integer n);
	begin
		i_qdsl_host_model.send({4'h0, cmd, ch, d, 4'h0}, n);
		repeat (8) @(posedge ref_clk);
	end
	endtask
	task pulse_clear;
	begin
		clear_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		clear_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
	end
	endtask
	task t_power;
	begin
		do_reset(1'b1);
		check(dacCodes_r, {4{16'h8000}});
		do_reset(1'b0);
		check(dacCodes_r, 64'h0);
	end
	endtask
	task t_write;
	begin
		frame(4'h3, 4'h2, 16'h1234, 32);
		expDac = {16'h0, 16'h1234, 32'h0};
		check(dacCodes_r, expDac);
	end
	endtask
	task t_strobe;
	begin
		frame(4'h0, 4'h0, 16'h5555, 32);
		check(dacCodes_r, expDac);
		check(i_qdsl_host_model.readBack, 32'h03212340);
		load_strobe_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		expDac[15:0] = 16'h5555;
		check(dacCodes_r, expDac);
		frame(4'h0, 4'h3, 16'h0f0f, 32);
		load_strobe_n <= 1'b1;
		expDac[63:48] = 16'h0f0f;
		check(dacCodes_r, expDac);
	end
	endtask
	task t_abort;
	begin
		frame(4'h3, 4'h1, 16'habcd, 31);
		check(dacCodes_r, expDac);
	end
	endtask
	// Strobe mask, broadcast write, update and write-update-all commands
	task t_mask;
	begin
		frame(4'h6, 4'h0, 16'h0002, 32);
		frame(4'h0, 4'hf, 16'h7777, 32);
		check(dacCodes_r, expDac);
		load_strobe_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		load_strobe_n <= 1'b1;
		expDac[31:16] = 16'h7777;
		check(dacCodes_r, expDac);
		repeat (4) @(posedge ref_clk);
		frame(4'h1, 4'h0, 16'h0000, 32);
		expDac[15:0] = 16'h7777;
		check(dacCodes_r, expDac);
		frame(4'h2, 4'h3, 16'h4444, 32);
		expDac = {16'h4444, {3{16'h7777}}};
		check(dacCodes_r, expDac);
		frame(4'h6, 4'h0, 16'h000f, 32);
	end
	endtask
	task t_clear;
	begin
		pulse_clear;
		check(dacCodes_r, 64'h0);
		frame(4'h5, 4'h0, 16'h0002, 32);
		pulse_clear;
		check(dacCodes_r, {4{16'hffff}});
		frame(4'h5, 4'h0, 16'h0001, 32);
		pulse_clear;
		check(dacCodes_r, {4{16'h8000}});
	end
	endtask
	initial
	begin
		expDac = 64'h0;
		t_power;
		t_write;
		t_strobe;
		t_abort;
		t_mask;
		t_clear;
		report_and_stop;
	end
	// Whole run is some 18 us
	initial
	begin
		#100000;
		bad_count = bad_count + 1;
		report_and_stop;
	end
endmodule
